// >>> bench/tb.sv
// Self-checking bench for the 16-bit timer control block
// Assumes the design files under rtl/ and an include path holding rtl/
`timescale 1ns/1ps
`include "timer16_defines.svh"
module tb;
  // ************
  // Signals
  // ************
  logic clock, rst, enable, read, write, capturePin, extCountPin, waitrequest, waveOutA, waveOutB;
  logic [7:0] address, vectorAck, timerFlags, rb;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [15:0] rw;
  int nMismatch, cmpCount;
  // Device under test
  timer16_mode_clock_capture_ctrl dut (.clock(clock), .rst(rst), .enable(enable), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .capturePin(capturePin), .extCountPin(extCountPin), .vectorAck(vectorAck),
    .waveOutA(waveOutA), .waveOutB(waveOutB), .timerFlags(timerFlags));
  // ************
  // Clock and common tasks
  // ************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Verdict, from the main sequence or the watchdog
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // Four-state compare so an unknown never matches
  task check(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One bus cycle; held until waitrequest is sampled low, no latency assumed
  task automatic bus_op(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    writedata <= {24'h000000, d};
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      nMismatch++;
      $display("[FAIL] t=%0t bus hang %h %h", $time, idx, 8'h00);
    end
    rb = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus_op
  task wr(input logic [5:0] idx, input logic [7:0] d);
    bus_op(1'b1, idx, d);
  endtask : wr
  task rd(input logic [5:0] idx);
    bus_op(1'b0, idx, 8'h00);
  endtask : rd
  // Pairs: high byte into temp first, low byte commits; read low first
  task wr16(input logic [5:0] lo, input logic [15:0] v);
    wr(lo + 6'h01, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16
  task rd16(input logic [5:0] lo);
    rd(lo);
    rw[7:0] = rb;
    rd(lo + 6'h01);
    rw[15:8] = rb;
  endtask : rd16
  // Capture pin pulse to v for hold cycles, then back, then time for sync and filter
  task pin_set(input logic v, input int hold);
    capturePin <= v;
    repeat (hold) @(posedge clock);
    capturePin <= ~v;
    repeat (14) @(posedge clock);
  endtask : pin_set
  // ************
  // Scenarios
  // ************
  task t_regs;
    rd(`R_CTRL_A); check(rb, 8'h00);
    rd(`R_CTRL_B); check(rb, 8'h00);
    rd(`R_FLAGS); check(rb, 8'h00);
    wr(`R_CTRL_B, 8'hE0); rd(`R_CTRL_B); check(rb, 8'hC0);
    wr(`R_CTRL_B, 8'h00);
    byteenable <= 4'h0;
    wr(`R_CTRL_A, 8'h55);
    byteenable <= 4'hF;
    rd(`R_CTRL_A); check(rb, 8'h00);
    wr(6'h3F, 8'hAA); rd(6'h3F); check(rb, 8'h00);
    wr16(`R_CNT_L, 16'hA55A); rd16(`R_CNT_L); check(rw, 16'hA55A);
    wr16(`R_CMPA_L, 16'h1357); rd16(`R_CMPA_L); check(rw, 16'h1357);
  endtask : t_regs
  // Counter stopped so the captured value is known
  task t_capture;
    wr16(`R_CNT_L, 16'h1234); wr(`R_FLAGS, 8'hFF);
    pin_set(1'b0, 40);
    rd16(`R_CAP_L); check(rw, 16'h1234);
    rd(`R_FLAGS); check(rb, 8'h20);
    wr(`R_FLAGS, 8'hFF); wr(`R_CTRL_B, 8'h40); wr16(`R_CNT_L, 16'h0BCD);
    // Pin idles high: the rise back after a low pulse is the capturing edge
    pin_set(1'b0, 20);
    rd16(`R_CAP_L); check(rw, 16'h0BCD);
    wr(`R_FLAGS, 8'hFF);
    // Lone falling edge while rising is selected
    capturePin <= 1'b0;
    repeat (20) @(posedge clock);
    rd(`R_FLAGS); check(rb, 8'h00);
    wr(`R_CTRL_B, 8'h18); wr16(`R_CNT_L, 16'h0777);
    pin_set(1'b1, 20);
    rd(`R_FLAGS); check(rb, 8'h00);
    rd16(`R_CAP_L); check(rw, 16'h0BCD);
  endtask : t_capture
  // Short glitch filtered out, long pulse passes
  task t_filter;
    wr(`R_CTRL_B, 8'hC0); wr(`R_FLAGS, 8'hFF);
    pin_set(1'b1, 2); rd(`R_FLAGS); check(rb, 8'h00);
    pin_set(1'b1, 8); rd(`R_FLAGS); check(rb, 8'h20);
    wr(`R_CTRL_B, 8'h40); wr(`R_FLAGS, 8'hFF);
    pin_set(1'b1, 2); rd(`R_FLAGS); check(rb, 8'h20);
  endtask : t_filter
  task t_force;
    logic [1:0] codes [4];
    logic expv [4];
    codes = '{2'b11, 2'b10, 2'b01, 2'b01};
    expv = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(`R_CTRL_B, 8'h00); wr(`R_FLAGS, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      wr(`R_CTRL_A, {codes[i], 6'h00}); wr(`R_CTRL_C, 8'h80);
      repeat (3) @(posedge clock);
      check(waveOutA, expv[i]);
    end
    wr(`R_CTRL_A, 8'h30); wr(`R_CTRL_C, 8'h40);
    repeat (3) @(posedge clock);
    check(waveOutB, 1'b1);
    rd(`R_CTRL_C); check(rb, 8'h00);
    wr16(`R_CNT_L, 16'h0050); wr(`R_CTRL_B, 8'h08); wr(`R_CTRL_A, 8'h40); wr(`R_CTRL_C, 8'h80);
    repeat (3) @(posedge clock);
    check(waveOutA, 1'b1);
    rd16(`R_CNT_L); check(rw, 16'h0050);
    rd(`R_FLAGS); check(rb, 8'h00);
    wr(`R_CTRL_A, 8'h81); wr(`R_CTRL_C, 8'h80);
    repeat (3) @(posedge clock);
    check(waveOutA, 1'b1);
  endtask : t_force
  // Three pin edges of the selected polarity give three counts
  task t_extclk;
    logic [2:0] cs [2];
    cs = '{3'h7, 3'h6};
    for (int i = 0; i < 2; i++) begin
      wr(`R_CTRL_A, 8'h00); wr(`R_CTRL_B, 8'h00); wr16(`R_CNT_L, 16'h0000); wr(`R_CTRL_B, {5'h00, cs[i]});
      repeat (3) begin
        extCountPin <= 1'b1;
        repeat (4) @(posedge clock);
        extCountPin <= 1'b0;
        repeat (4) @(posedge clock);
      end
      repeat (4) @(posedge clock);
      wr(`R_CTRL_B, 8'h00);
      repeat (20) @(posedge clock);
      rd16(`R_CNT_L); check(rw, 16'h0003);
    end
  endtask : t_extclk
  // Prescaler phase is free running, so allow a few counts of slack
  task t_prescale;
    int span [5];
    int ex [5];
    span = '{100, 800, 6400, 25600, 10240};
    ex = '{100, 100, 100, 100, 10};
    for (int i = 0; i < 5; i++) begin
      wr16(`R_CNT_L, 16'h0000); wr(`R_CTRL_B, 8'(i + 1));
      repeat (span[i] - 4) @(posedge clock);
      wr(`R_CTRL_B, 8'h00); rd16(`R_CNT_L);
      check(16'(int'(rw) >= ex[i] - 3 && int'(rw) <= ex[i] + 3), 16'h0001);
    end
  endtask : t_prescale
  task t_match;
    wr16(`R_CMPA_L, 16'h0010); wr16(`R_CNT_L, 16'h0000); wr(`R_FLAGS, 8'hFF);
    wr(`R_CTRL_B, 8'h01); repeat (40) @(posedge clock); wr(`R_CTRL_B, 8'h00);
    rd(`R_FLAGS); check(rb & 8'h03, 8'h02);
    vectorAck <= 8'h02;
    @(posedge clock);
    vectorAck <= 8'h00;
    repeat (2) @(posedge clock);
    check(timerFlags[1], 1'b0);
    wr16(`R_CMPA_L, 16'h0005); wr16(`R_CNT_L, 16'h0100); wr(`R_FLAGS, 8'hFF); wr(`R_CTRL_B, 8'h01);
    wr16(`R_CNT_L, 16'h0005); repeat (20) @(posedge clock); wr(`R_CTRL_B, 8'h00);
    rd(`R_FLAGS); check(rb[1], 1'b0);
  endtask : t_match
  // Modes 0, 13, 5, 7, 1, 4, 9: overflow point and top; compare A holds 5 here
  task t_modes;
    logic [7:0] ma [7];
    logic [7:0] mb [7];
    logic [15:0] st [7];
    logic [15:0] tp [7];
    logic ov [7];
    ma = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h01, 8'h00, 8'h01};
    mb = '{8'h00, 8'h18, 8'h08, 8'h08, 8'h00, 8'h08, 8'h10};
    st = '{16'hFFF0, 16'hFFF0, 16'h00F0, 16'h03F0, 16'h00F0, 16'h0000, 16'h0000};
    tp = '{`TOP_16, `TOP_16, `TOP_8, `TOP_10, `TOP_8, 16'h0005, 16'h0005};
    ov = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 7; i++) begin
      wr(`R_CTRL_A, ma[i]); wr(`R_CTRL_B, mb[i]); wr16(`R_CNT_L, st[i]); wr(`R_FLAGS, 8'hFF);
      wr(`R_CTRL_B, mb[i] | 8'h01); repeat (40) @(posedge clock); wr(`R_CTRL_B, mb[i]);
      rd(`R_FLAGS); check(rb[0], ov[i]);
      rd16(`R_CNT_L); check(rw <= tp[i], 1'b1);
      wr(`R_FLAGS, 8'h01); rd(`R_FLAGS); check(rb[0], 1'b0);
    end
  endtask : t_modes
  // ************
  // Main sequence and watchdog
  // ************
  initial begin
    rst = 1'b1; enable = 1'b1; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h00000000;
    byteenable = 4'hF; capturePin = 1'b1; extCountPin = 1'b0; vectorAck = 8'h00;
    nMismatch = 0; cmpCount = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs(); t_capture(); t_filter(); t_force(); t_extclk(); t_prescale(); t_match(); t_modes();
    finish_test();
  end
  // Whole run is about 44k cycles; this margin cuts a hang
  initial begin
    repeat (90000) @(posedge clock);
    nMismatch++;
    finish_test();
  end
endmodule : tb

// >>> rtl/capture_cond.sv
// Capture pin conditioner: synchroniser, noise filter, edge select
// Assumes the capture pin is asynchronous to clock
`timescale 1ns/1ps
`include "timer16_defines.svh"
module capture_cond (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic capturePin,
  timer_sub_if.capture bus
);
  timer16_pkg::cap_state_t s; // Registered state
  timer16_pkg::cap_state_t next_s; // Next state

  // Filtered level moves only on a full run of equal samples
  always_comb begin
    next_s = s;
    next_s.sync = {s.sync[0], capturePin};
    next_s.hist = {s.hist[`FILT_N-2:0], s.sync[1]};
    if (!bus.filterEn) begin
      next_s.level = s.sync[1];
    end else if (&next_s.hist) begin
      next_s.level = 1'b1;
    end else if (~|next_s.hist) begin
      next_s.level = 1'b0;
    end
    // Edge of the chosen direction
    next_s.hit = (next_s.level != s.level) && (next_s.level == bus.edgeSel);
  end

  // State register, frozen while enable is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (enable) begin
      s <= next_s;
    end
  end

  assign bus.captureEvent = s.hit;
endmodule : capture_cond

// >>> rtl/clock_source_sel.sv
// Counter clock enable: prescaler taps or external pin edges
// Assumes the external pin is asynchronous to clock
`timescale 1ns/1ps
`include "timer16_defines.svh"
module clock_source_sel (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic extCountPin,
  timer_sub_if.clkgen bus
);
  timer16_pkg::clk_state_t s; // Registered state
  timer16_pkg::clk_state_t next_s; // Next state

  // Prescaler tap reached
  function automatic logic tap(input logic [9:0] d, input logic [9:0] m);
    tap = (d & m) == m;
  endfunction : tap

  // Divider never stops, so a prescaled start may take up to N+1 cycles
  always_comb begin
    next_s = s;
    next_s.div = s.div + 10'h001;
    next_s.sync = {s.sync[0], extCountPin};
    next_s.last = s.sync[1];
    case (bus.clockSel)
      `CS_STOP: next_s.tick = 1'b0;
      `CS_DIV1: next_s.tick = 1'b1;
      `CS_DIV8: next_s.tick = tap(s.div, `PM_8);
      `CS_DIV64: next_s.tick = tap(s.div, `PM_64);
      `CS_DIV256: next_s.tick = tap(s.div, `PM_256);
      `CS_DIV1024: next_s.tick = tap(s.div, `PM_1024);
      `CS_FALL: next_s.tick = s.last && !s.sync[1];
      default: next_s.tick = !s.last && s.sync[1];
    endcase
  end

  // State register, frozen while enable is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (enable) begin
      s <= next_s;
    end
  end

  assign bus.tick = s.tick;
endmodule : clock_source_sel

// >>> rtl/timer16_defines.svh
// Constants of the 16-bit timer control block: indices, fields, tops
// Assumes inclusion by bare name from files under rtl/
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH
// Register indices; byte address is four times the index
`define R_CTRL_A 6'h2F
`define R_CTRL_B 6'h2E
`define R_CTRL_C 6'h22
`define R_CNT_L 6'h2C
`define R_CNT_H 6'h2D
`define R_CMPA_L 6'h2A
`define R_CMPA_H 6'h2B
`define R_CMPB_L 6'h28
`define R_CMPB_H 6'h29
`define R_CAP_L 6'h26
`define R_CAP_H 6'h27
`define R_FLAGS 6'h20
// Field positions
`define CA_COMA 7:6
`define CA_COMB 5:4
`define CA_WGM 1:0
`define CB_FILT 7
`define CB_EDGE 6
`define CB_RSVD 5
`define CB_WGM 4:3
`define CB_CS 2:0
`define CC_FA 7
`define CC_FB 6
`define F_OVF 0
`define F_MA 1
`define F_MB 2
`define F_CAP 5
// Fixed counter tops
`define TOP_16 16'hFFFF
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF
`define BOTTOM 16'h0000
// Clock select codes and prescaler tap masks
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_FALL 3'h6
`define PM_8 10'h007
`define PM_64 10'h03F
`define PM_256 10'h0FF
`define PM_1024 10'h3FF
// Equal samples needed by the capture filter
`define FILT_N 4
`endif

// >>> rtl/timer16_mode_clock_capture_ctrl.sv
// Control part of a 16-bit timer: modes, clocking, capture, 16-bit access
// Assumes an Avalon-MM master with waitrequest and one system clock
//
// Functional notes
// (R1) Four-bit mode from control A and B
// (R2) Normal/CLEAR_ON_MATCH_MODE: tops FFFF, A, capture; immediate
// (R3) Phase correct: buffers at TOP, overflow BOTTOM
// (R4) Fast PWM: buffers at TOP, overflow TOP
// (R5) Phase-frequency: buffers and overflow at BOTTOM
// (R6) Filter needs four equal capture samples
// (R7) Edge select: zero falling, one rising
// (R8) Capture copies count and sets flag
// (R9) Capture-as-top modes disable captures
// (R10) Control B bit five reads zero
// (R11) Clock select: stop, prescale, pin edges
// (R12) Pin clocks counter regardless of direction
// (R13) Force strobes act only in non-PWM
// (R14) Force applies compare action to output
// (R15) Force sets no flag, clears no counter
// (R16) Force bits always read zero
// (R17) Sixteen-bit access through shared temp byte
// (R18) Count write blocks next tick's matches
// (R19) Non-PWM output codes: off/toggle/clear/set
// (R20) Overflow flag cleared by vector or one
// (R21) Match flag sets cycle after equality
// (R22) Prescale as enable pulses, one clock
// (R23) Reserved mode thirteen behaves as normal; the code keeps overflow at FFFF but wraps the count at TOP 00FF
`timescale 1ns/1ps
`include "timer16_defines.svh"
module timer16_mode_clock_capture_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic capturePin,
  input wire logic extCountPin,
  input wire logic [7:0] vectorAck,
  output logic waveOutA,
  output logic waveOutB,
  output logic [7:0] timerFlags
);
  // ****************************************
  // State and helpers
  // ****************************************
  timer16_pkg::ctrl_state_t s; // Registered state
  timer16_pkg::ctrl_state_t next_s; // Next state
  timer16_pkg::mode_info_t mi; // Decoded mode
  logic [3:0] mode; // Waveform mode select
  logic [15:0] top; // Current TOP
  logic [5:0] idx; // Register index
  logic [7:0] wd; // Write byte
  logic first; // First cycle of a request
  logic wr; // Accepted byte write
  logic cntWr; // Count low byte written
  logic pwm; // Any PWM family
  logic atTop; // Count at TOP
  logic atBot; // Count at BOTTOM
  logic hitA; // Compare A match this tick
  logic hitB; // Compare B match this tick
  logic capHit; // Capture taken
  logic forceA; // Effective force A
  logic forceB; // Effective force B
  logic ovfHit; // Overflow point
  logic upd; // Compare buffer load
  logic [7:0] rdByte; // Read mux
  logic [7:0] setF; // Flag sets
  logic [7:0] clrF; // Flag clears

  timer_sub_if sub(); // Link to helpers

  // ****************************************
  // Functions
  // ****************************************
  // Mode decode; reserved code falls to normal, with a fixed TOP of 00FF
  function automatic timer16_pkg::mode_info_t modeInfo(input logic [3:0] m);
    timer16_pkg::mode_info_t r;
    r.kind = timer16_pkg::K_NORMAL; // see (R23)
    r.topSrc = timer16_pkg::T_FIXED;
    r.upd = timer16_pkg::P_NOW;
    r.ovf = timer16_pkg::P_MAX;
    case (m[1:0])
      2'h1: r.fixedTop = `TOP_8;
      2'h2: r.fixedTop = `TOP_9;
      2'h3: r.fixedTop = `TOP_10;
      default: r.fixedTop = `TOP_16;
    endcase
    // Upper modes except reserved 13: even takes capture, odd takes A
    if (m[3]) begin
      r.topSrc = m[0] ? timer16_pkg::T_CMPA : timer16_pkg::T_CAP;
    end
    case (m)
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: begin // see (R3)
        r.kind = timer16_pkg::K_PHASE;
        r.upd = timer16_pkg::P_TOP;
        r.ovf = timer16_pkg::P_BOTTOM;
      end
      4'h4, 4'hC: begin // see (R2)
        r.kind = timer16_pkg::K_CTC;
        r.topSrc = m[3] ? timer16_pkg::T_CAP : timer16_pkg::T_CMPA;
      end
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin // see (R4)
        r.kind = timer16_pkg::K_FAST;
        r.upd = timer16_pkg::P_TOP;
        r.ovf = timer16_pkg::P_TOP;
      end
      4'h8, 4'h9: begin // see (R5)
        r.kind = timer16_pkg::K_PFC;
        r.upd = timer16_pkg::P_BOTTOM;
        r.ovf = timer16_pkg::P_BOTTOM;
      end
      4'hD: begin // see (R23)
        r.topSrc = timer16_pkg::T_FIXED;
      end
      default: begin // Mode 0, see (R2)
        r.kind = timer16_pkg::K_NORMAL;
      end
    endcase
    return r;
  endfunction : modeInfo

  // Non-PWM compare action on an output
  function automatic logic comApply(input logic [1:0] com, input logic cur);
    case (com)
      2'h1: comApply = !cur; // see (R19)
      2'h2: comApply = 1'b0;
      2'h3: comApply = 1'b1;
      default: comApply = cur;
    endcase
  endfunction : comApply

  // ****************************************
  // Decode
  // ****************************************
  assign mode = {s.ctrlB[`CB_WGM], s.ctrlA[`CA_WGM]}; // see (R1)
  assign mi = modeInfo(mode);
  assign top = (mi.topSrc == timer16_pkg::T_CMPA) ? s.cmpA :
               (mi.topSrc == timer16_pkg::T_CAP) ? s.capture : mi.fixedTop;
  assign pwm = (mi.kind != timer16_pkg::K_NORMAL) && (mi.kind != timer16_pkg::K_CTC);
  assign atTop = s.count == top;
  assign atBot = s.count == `BOTTOM;

  // Bus decode; one wait cycle per request
  assign idx = address[7:2];
  assign wd = writedata[7:0];
  assign first = (read || write) && s.waitrequest;
  assign wr = write && !s.waitrequest && byteenable[0];
  assign cntWr = wr && (idx == `R_CNT_L);

  // Matches are held off for one tick after a count write
  assign hitA = sub.tick && (s.count == s.cmpA) && !s.suppress; // see (R18)
  assign hitB = sub.tick && (s.count == s.cmpB) && !s.suppress;

  // Pin is ignored while capture holds TOP
  assign capHit = sub.captureEvent && (mi.topSrc != timer16_pkg::T_CAP); // see (R9)

  // Force strobes only in non-PWM modes
  assign forceA = wr && (idx == `R_CTRL_C) && wd[`CC_FA] && !pwm; // see (R13)
  assign forceB = wr && (idx == `R_CTRL_C) && wd[`CC_FB] && !pwm;

  // Helper comb: flags, overflow point, buffer load, read mux
  always_comb begin
    case (mi.ovf)
      timer16_pkg::P_MAX: ovfHit = sub.tick && (s.count == `TOP_16); // see (R2)
      timer16_pkg::P_TOP: ovfHit = sub.tick && atTop; // see (R4)
      timer16_pkg::P_BOTTOM: ovfHit = sub.tick && atBot && s.down; // see (R3) (R5)
      default: ovfHit = 1'b0;
    endcase
    case (mi.upd)
      timer16_pkg::P_TOP: upd = sub.tick && atTop;
      timer16_pkg::P_BOTTOM: upd = sub.tick && atBot;
      default: upd = 1'b1;
    endcase
    setF = 8'h00;
    setF[`F_OVF] = ovfHit;
    setF[`F_MA] = hitA; // see (R21)
    setF[`F_MB] = hitB;
    setF[`F_CAP] = capHit || (sub.tick && atTop && (mi.topSrc == timer16_pkg::T_CAP)); // see (R8)
    // Clear by a written one or a serviced vector
    clrF = vectorAck; // see (R20)
    if (wr && (idx == `R_FLAGS)) begin
      clrF = clrF | wd;
    end
    case (idx)
      `R_CTRL_A: rdByte = s.ctrlA;
      `R_CTRL_B: rdByte = s.ctrlB; // see (R10)
      `R_CNT_L: rdByte = s.count[7:0];
      `R_CNT_H: rdByte = s.temp; // see (R17)
      `R_CMPA_L: rdByte = s.bufA[7:0];
      `R_CMPA_H: rdByte = s.bufA[15:8];
      `R_CMPB_L: rdByte = s.bufB[7:0];
      `R_CMPB_H: rdByte = s.bufB[15:8];
      `R_CAP_L: rdByte = s.capture[7:0];
      `R_CAP_H: rdByte = s.temp;
      `R_FLAGS: rdByte = s.flags;
      default: rdByte = 8'h00; // Control C and unmapped, see (R16)
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.waitrequest = !first;
    // Read data latched in the wait cycle
    if (first && read) begin
      next_s.readdata = {24'h000000, rdByte};
      // Low byte read snapshots the high byte
      if (idx == `R_CNT_L) begin
        next_s.temp = s.count[15:8]; // see (R17)
      end
      if (idx == `R_CAP_L) begin
        next_s.temp = s.capture[15:8];
      end
    end
    // Counter on each clock enable pulse
    if (sub.tick) begin
      next_s.suppress = 1'b0;
      if ((mi.kind == timer16_pkg::K_PHASE) || (mi.kind == timer16_pkg::K_PFC)) begin
        // Dual slope turns at TOP and BOTTOM
        if (!s.down && atTop) begin
          next_s.down = 1'b1;
          next_s.count = s.count - 16'h0001;
        end else if (s.down && atBot) begin
          next_s.down = 1'b0;
          next_s.count = s.count + 16'h0001;
        end else if (s.down) begin
          next_s.count = s.count - 16'h0001;
        end else begin
          next_s.count = s.count + 16'h0001;
        end
      end else begin
        // Single slope; force strobes never reach here, see (R15)
        next_s.down = 1'b0;
        next_s.count = atTop ? `BOTTOM : s.count + 16'h0001;
      end
    end
    // Double buffer load point
    if (upd) begin
      next_s.cmpA = s.bufA;
      next_s.cmpB = s.bufB;
    end
    // Capture of the count
    if (capHit) begin
      next_s.capture = s.count; // see (R8)
    end
    // Waveform outputs; PWM shaping lives outside
    if (!pwm && (hitA || forceA)) begin
      next_s.waveA = comApply(s.ctrlA[`CA_COMA], s.waveA); // see (R14)
    end
    if (!pwm && (hitB || forceB)) begin
      next_s.waveB = comApply(s.ctrlA[`CA_COMB], s.waveB);
    end
    // Set wins over clear; force never sets a flag
    next_s.flags = (s.flags & ~clrF) | setF; // see (R15) (R20)
    // Register writes win over counting
    if (wr) begin
      case (idx)
        `R_CTRL_A: next_s.ctrlA = wd;
        `R_CTRL_B: begin
          next_s.ctrlB = wd;
          next_s.ctrlB[`CB_RSVD] = 1'b0; // see (R10)
        end
        `R_CNT_H, `R_CMPA_H, `R_CMPB_H, `R_CAP_H: next_s.temp = wd; // see (R17)
        `R_CNT_L: begin
          next_s.count = {s.temp, wd};
          next_s.suppress = 1'b1; // see (R18)
        end
        `R_CMPA_L: next_s.bufA = {s.temp, wd};
        `R_CMPB_L: next_s.bufB = {s.temp, wd};
        `R_CAP_L: next_s.capture = {s.temp, wd};
        default: begin
          // Control C is strobes only; flags handled above
        end
      endcase
    end
  end

  // ****************************************
  // Registers and outputs
  // ****************************************
  // Whole state in one register, frozen while enable is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.waitrequest <= 1'b1;
    end else if (enable) begin
      s <= next_s;
    end
  end

  assign readdata = s.readdata;
  assign waitrequest = s.waitrequest;
  assign waveOutA = s.waveA;
  assign waveOutB = s.waveB;
  assign timerFlags = s.flags;

  // ****************************************
  // Helpers
  // ****************************************
  assign sub.clockSel = s.ctrlB[`CB_CS]; // see (R11)
  assign sub.filterEn = s.ctrlB[`CB_FILT]; // see (R6)
  assign sub.edgeSel = s.ctrlB[`CB_EDGE]; // see (R7)

  // Pin edges count whatever the pin's direction, see (R12) (R22)
  clock_source_sel uClk (
    .clock(clock),
    .rst(rst),
    .enable(enable),
    .extCountPin(extCountPin),
    .bus(sub.clkgen)
  );

  // Filtered and edge-selected capture events
  capture_cond uCap (
    .clock(clock),
    .rst(rst),
    .enable(enable),
    .capturePin(capturePin),
    .bus(sub.capture)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !enable);

  sequence ctrlCRead;
    read && first && (idx == `R_CTRL_C);
  endsequence
  sequence ctrlBRead;
    read && first && (idx == `R_CTRL_B);
  endsequence
  sequence countWrite;
    cntWr;
  endsequence

  matchFlag_a: assert property (hitA |=> s.flags[`F_MA]) // see (R21)
    else $error("match A did not set its flag");
  suppressMatch_a: assert property (countWrite |=> s.suppress && !hitA && !hitB) // see (R18)
    else $error("match not blocked after count write");
  captureCopy_a: assert property (capHit && !(wr && (idx == `R_CAP_L))
    |=> (s.capture == $past(s.count)) && s.flags[`F_CAP]) // see (R8)
    else $error("capture did not copy count or set flag");
  captureOff_a: assert property ((mi.topSrc == timer16_pkg::T_CAP) && !wr |=> $stable(s.capture)) // see (R9)
    else $error("capture taken while capture is top");
  forceNoFlag_a: assert property (forceA && !hitA && !s.flags[`F_MA] |=> !s.flags[`F_MA]) // see (R15)
    else $error("force strobe set a flag");
  forceZero_a: assert property (ctrlCRead |=> !readdata[`CC_FA] && !readdata[`CC_FB]) // see (R16)
    else $error("force bits read nonzero");
  reservedZero_a: assert property (ctrlBRead |=> !readdata[`CB_RSVD]) // see (R10)
    else $error("reserved bit reads nonzero");
  clockStop_a: assert property ((s.ctrlB[`CB_CS] == `CS_STOP) [*2] |-> !sub.tick) // see (R11)
    else $error("tick while clock stopped");
  pwmForce_a: assert property (wr && (idx == `R_CTRL_C) && wd[`CC_FA] && pwm |=> $stable(s.waveA)) // see (R13)
    else $error("force acted in PWM mode");
  ovfTop_a: assert property (sub.tick && atTop && (mi.ovf == timer16_pkg::P_TOP) |=> s.flags[`F_OVF]) // see (R4)
    else $error("overflow not set at top");
  setWins_a: assert property (ovfHit && clrF[`F_OVF] |=> s.flags[`F_OVF]) // see (R20)
    else $error("clear beat set on overflow flag");
endmodule : timer16_mode_clock_capture_ctrl

// >>> rtl/timer16_pkg.sv
// Types of the 16-bit timer control block
// Assumes timer16_defines.svh on the include path
`include "timer16_defines.svh"
package timer16_pkg;
  // Counting family of a waveform mode
  typedef enum logic [2:0] {K_NORMAL, K_CTC, K_FAST, K_PHASE, K_PFC} kind_t;
  // Where TOP comes from
  typedef enum logic [1:0] {T_FIXED, T_CMPA, T_CAP} top_src_t;
  // Point in the count where an event happens
  typedef enum logic [1:0] {P_NOW, P_TOP, P_BOTTOM, P_MAX} point_t;
  // Decoded waveform mode
  typedef struct packed {
    kind_t kind;
    top_src_t topSrc;
    logic [15:0] fixedTop;
    point_t upd;
    point_t ovf;
  } mode_info_t;
  // Clock source state
  typedef struct packed {logic [9:0] div; logic [1:0] sync; logic last; logic tick;} clk_state_t;
  // Capture conditioner state
  typedef struct packed {logic [1:0] sync; logic [`FILT_N-1:0] hist; logic level; logic hit;} cap_state_t;
  // Control block state
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [7:0] temp;
    logic [7:0] flags;
    logic [15:0] count;
    logic [15:0] cmpA;
    logic [15:0] cmpB;
    logic [15:0] bufA;
    logic [15:0] bufB;
    logic [15:0] capture;
    logic down;
    logic suppress;
    logic waveA;
    logic waveB;
  } ctrl_state_t;
endpackage : timer16_pkg

// >>> rtl/timer_sub_if.sv
// Signals between the timer control and its clock and capture helpers
// Assumes all three parties run on the same system clock
`timescale 1ns/1ps
interface timer_sub_if;
  logic [2:0] clockSel;
  logic tick;
  logic filterEn;
  logic edgeSel;
  logic captureEvent;
  modport ctrl (output clockSel, filterEn, edgeSel, input tick, captureEvent);
  modport clkgen (input clockSel, output tick);
  modport capture (input filterEn, edgeSel, output captureEvent);
endinterface : timer_sub_if
